// ===== hw/asr_device.sv
// Converter end: internally timed conversion and serial result shifter
`timescale 1ns/1ps
module asr_device (
   // Internal conversion clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst_n,
   // Link
   asr_link_if.dev                         link,
   // Sampled input value, stands in for the analog input
   input  wire logic [asr_pkg::RES_BITS-1:0] i_sample,
   // Status
   output logic      [asr_pkg::RES_BITS-1:0] o_result,
   output logic                            o_result_valid,
   output logic                            o_converting,
   output logic                            o_ref_internal,
   output logic                            o_powered_down
);
   import asr_pkg::*;

   typedef enum logic [1:0] {ST_TRACK, ST_CONV, ST_DONE} asr_dev_st_e;

   // ---------------------------------------------------------------
   // Pin synchronisation and decode
   // ---------------------------------------------------------------
   logic [2:0]          pin_s;
   logic                cs_prev_q;
   logic                cs_fall;
   logic                cs_rise;
   logic                pd_off;
   logic                ref_int;
   asr_dev_st_e         st_q;
   logic [RES_BITS-1:0] hold_q;
   logic [RES_BITS-1:0] sar_q;
   logic [RES_BITS-1:0] sar_trial;
   logic [3:0]          bit_idx_q;
   logic [7:0]          step_q;
   logic                last_step;
   logic                eoc_q;
   logic                oe_q;
   logic                sclk_rst_n;
   logic                started_q;
   logic                dout_q;
   logic [RES_BITS-1:0] shift_q;

   // Select resets high so no false start follows reset
   asr_sync #(.WIDTH(3), .RST_VAL(3'h4)) u_pin_sync (
      .i_clk   (i_clk_sys),
      .i_rst_n (i_rst_n),
      .i_async ({link.cs_n, link.pd_oe, link.pd_o}),
      .o_sync  (pin_s)
   );

   // Select edges and three-level pin states
   assign cs_fall = cs_prev_q & ~pin_s[2];
   assign cs_rise = ~cs_prev_q & pin_s[2];
   assign pd_off  = pin_s[1] & ~pin_s[0];             // [R16]
   assign ref_int = pin_s[1] & pin_s[0];              // [R16]

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= pin_s[2];
      end
   end

   // ---------------------------------------------------------------
   // Conversion sequencing
   // ---------------------------------------------------------------
   assign last_step = (step_q == 8'h00) && (bit_idx_q == 4'h0);

   // Rising select abandons a conversion and returns to tracking
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= ST_TRACK;
      end else begin
         case (st_q)
            ST_TRACK: begin
               if (cs_fall && !pd_off) begin
                  st_q <= ST_CONV;                    // [R01]
               end
            end
            ST_CONV: begin
               if (cs_rise || pd_off) begin
                  st_q <= ST_TRACK;                   // [R21]
               end else if (last_step) begin
                  st_q <= ST_DONE;                    // [R19]
               end
            end
            ST_DONE: begin
               if (cs_rise || pd_off) begin
                  st_q <= ST_TRACK;
               end
            end
            default: begin
               st_q <= ST_TRACK;
            end
         endcase
      end
   end

   // Trial value: current result with the bit under test set
   assign sar_trial = sar_q | (RES_BITS'(1) << bit_idx_q);

   // Sample freeze and successive approximation, one bit per step
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_q    <= '0;
         sar_q     <= '0;
         bit_idx_q <= 4'h0;
         step_q    <= 8'h00;
         o_result  <= '0;
      end else if (st_q == ST_TRACK && cs_fall && !pd_off) begin
         hold_q    <= i_sample;                       // [R01]
         sar_q     <= '0;
         bit_idx_q <= 4'(RES_BITS - 1);
         step_q    <= 8'(STEP_CYC - 1);
      end else if (st_q == ST_CONV) begin
         if (step_q == 8'h00) begin
            step_q <= 8'(STEP_CYC - 1);
            // Straight binary code over all 4096 codes, found in twelve steps
            if (sar_trial <= hold_q) begin            // [R17]
               sar_q <= sar_trial;
            end
            if (bit_idx_q == 4'h0) begin
               o_result <= (sar_trial <= hold_q) ? sar_trial : sar_q; // [R04]
            end else begin
               bit_idx_q <= bit_idx_q - 4'h1;
            end
         end else begin
            step_q <= step_q - 8'h01;
         end
      end
   end

   // End-of-conversion flag, dropped when the frame ends
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         eoc_q <= 1'b0;
      end else if (cs_rise || pd_off || cs_fall) begin
         eoc_q <= 1'b0;                               // [R01]
      end else if (st_q == ST_CONV && last_step) begin
         eoc_q <= 1'b1;                               // [R03]
      end
   end

   // Output enable and status flops
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_q           <= 1'b0;
         o_result_valid <= 1'b0;
         o_converting   <= 1'b0;
         o_ref_internal <= 1'b0;
         o_powered_down <= 1'b0;
      end else begin
         oe_q           <= ~pin_s[2] & ~pd_off;       // [R18]
         o_result_valid <= (st_q == ST_CONV && last_step) ||
                           (st_q == ST_DONE && !cs_rise && !pd_off);
         o_converting   <= (st_q == ST_CONV) && !last_step && !cs_rise;
         o_ref_internal <= ref_int;
         o_powered_down <= pd_off;
      end
   end

   // ---------------------------------------------------------------
   // Serial shifter on the link clock
   // ---------------------------------------------------------------
   // High select clears the shifter; the result word is static by the
   // time the clock starts, so it crosses without a handshake
   assign sclk_rst_n = i_rst_n & ~link.cs_n;

   always_ff @(negedge link.sclk or negedge sclk_rst_n) begin
      if (!sclk_rst_n) begin
         started_q <= 1'b0;
         dout_q    <= 1'b0;
         shift_q   <= '0;
      end else if (!started_q) begin
         started_q <= 1'b1;
         dout_q    <= o_result[RES_BITS-1];           // [R05]
         shift_q   <= {o_result[RES_BITS-2:0], 1'b0}; // [R06]
      end else begin
         dout_q    <= shift_q[RES_BITS-1];            // [R05]
         shift_q   <= {shift_q[RES_BITS-2:0], 1'b0};  // [R07]
      end
   end

   // Marker from end-of-conversion until the first falling edge
   assign link.dout_o  = started_q ? dout_q : eoc_q;  // [R03]
   assign link.dout_oe = oe_q;                        // [R18]

endmodule

// ===== hw/asr_host.sv
// Host end: serial clock master, conversion start and result readout
//
// Behaviour
// R01: Select fall holds sample, starts, drives low.
// R02: Serial clock stays low during conversion.
// R03: Data output rising marks end of conversion.
// R04: Conversion self-timed, result held for later.
// R05: Bits change on falling edges, MSB first.
// R06: Marker plus twelve bits, thirteen falling edges.
// R07: Extra edges give zeros, change nothing.
// R08: Raise select at or after thirteenth fall.
// R09: Keep select high the minimum time.
// R10: After abort wait acquisition time.
// R11: Wait conversion time or data rising.
// R12: Clock rate and phase widths limited.
// R13: Sample bits on rising clock edges.
// R14: No conversions during power-up intervals.
// R15: Wait wake time after leaving power-down.
// R16: Power-down pin has three levels.
// R17: Result is straight binary, 4096 codes.
// R18: Data output floats while select high.
// R19: Conversion ends within maximum conversion time.
// R20: Acquisition time never below minimum.
// R21: Early select rise abandons the conversion.
`timescale 1ns/1ps
module asr_host #(
   parameter int unsigned WAIT_W    = 21,
   parameter int unsigned REF_CHARGE = asr_pkg::REF_CHARGE_CYC
) (
   // Clock and reset
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_rst_n,
   // Link
   asr_link_if.host                          link,
   // User requests
   input  wire asr_pkg::asr_pd_mode_e        i_pd_mode,
   input  wire logic                         i_start,
   input  wire logic                         i_abort,
   // User results
   output logic      [asr_pkg::RES_BITS-1:0] o_data,
   output logic                              o_data_valid,
   output logic                              o_marker_err,
   output logic                              o_ready,
   output logic                              o_busy
);
   import asr_pkg::*;

   typedef enum logic [2:0] {
      H_BOOT, H_WAIT, H_OFF, H_IDLE, H_CONV, H_SHIFT, H_GAP
   } asr_host_st_e;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   asr_host_st_e        st_q;
   asr_pd_mode_e        mode_q;
   logic [WAIT_W-1:0]   wait_q;
   logic                mode_chg;
   logic                dout_s;
   logic [4:0]          phase_q;
   logic [3:0]          edge_q;
   logic                toggle;
   logic                rise;
   logic                fall;
   logic                frame_done;
   logic [RES_BITS:0]   rx_q;
   logic                cs_n_q;
   logic                sclk_q;
   logic                pd_o_q;
   logic                pd_oe_q;

   // Settling time before conversions after power-up or wake
   function automatic logic [WAIT_W-1:0] settle_cyc(
      input asr_pd_mode_e mode,
      input logic         from_off
   );
      logic [WAIT_W-1:0] cyc;
      cyc = '0;
      case (mode)
         PD_INT_REF: cyc = WAIT_W'(REF_CHARGE);                    // [R14]
         PD_EXT_REF: cyc = from_off ? WAIT_W'(WAKE_CYC)            // [R15]
                                    : WAIT_W'(RESET_CYC);          // [R14]
         default:    cyc = '0;
      endcase
      return cyc;
   endfunction

   // ---------------------------------------------------------------
   // Data line synchronisation
   // ---------------------------------------------------------------
   asr_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_dout_sync (
      .i_clk   (i_clk_sys),
      .i_rst_n (i_rst_n),
      .i_async (link.dout),
      .o_sync  (dout_s)
   );

   assign mode_chg = (i_pd_mode != mode_q);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q <= PD_INT_REF;
      end else begin
         mode_q <= i_pd_mode;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer: select and wait counter
   // ---------------------------------------------------------------
   // A mode change ends any frame; the wait restarts from the new mode
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q   <= H_BOOT;
         wait_q <= '0;
         cs_n_q <= 1'b1;
      end else if (mode_chg && st_q != H_BOOT) begin
         cs_n_q <= 1'b1;
         if (i_pd_mode == PD_OFF) begin
            st_q <= H_OFF;
         end else begin
            st_q   <= H_WAIT;
            wait_q <= settle_cyc(i_pd_mode, mode_q == PD_OFF);
         end
      end else begin
         case (st_q)
            H_BOOT: begin
               st_q   <= (mode_q == PD_OFF) ? H_OFF : H_WAIT;
               wait_q <= settle_cyc(mode_q, 1'b0);            // [R14]
            end
            H_WAIT: begin
               if (wait_q == '0) begin
                  st_q <= H_IDLE;
               end else begin
                  wait_q <= wait_q - 1'b1;
               end
            end
            H_OFF: begin
               st_q <= H_OFF;
            end
            H_IDLE: begin
               if (i_start) begin
                  cs_n_q <= 1'b0;
                  wait_q <= WAIT_W'(CONV_CYC);
                  st_q   <= H_CONV;
               end
            end
            H_CONV: begin
               if (i_abort) begin
                  cs_n_q <= 1'b1;
                  wait_q <= WAIT_W'(ACQ_CYC);                 // [R10] [R20]
                  st_q   <= H_GAP;
               end else if (dout_s || wait_q == '0) begin
                  st_q <= H_SHIFT;                            // [R11]
               end else begin
                  wait_q <= wait_q - 1'b1;
               end
            end
            H_SHIFT: begin
               if (frame_done) begin
                  cs_n_q <= 1'b1;                             // [R08]
                  wait_q <= WAIT_W'(GAP_CYC);                 // [R09] [R20]
                  st_q   <= H_GAP;
               end
            end
            H_GAP: begin
               if (wait_q == '0) begin
                  st_q <= H_IDLE;
               end else begin
                  wait_q <= wait_q - 1'b1;
               end
            end
            default: begin
               st_q <= H_BOOT;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Serial clock divider
   // ---------------------------------------------------------------
   // Equal phases of HALF_CYC meet both the rate and phase limits
   assign toggle     = (st_q == H_SHIFT) && (phase_q == 5'(HALF_CYC - 1));
   assign rise       = toggle && !sclk_q;
   assign fall       = toggle && sclk_q;
   assign frame_done = fall && (edge_q == 4'(FRAME_EDGES - 1));       // [R06]

   // Clock held low outside readout, so never during conversion
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_q <= 5'h00;
         sclk_q  <= 1'b0;
         edge_q  <= 4'h0;
      end else if (st_q != H_SHIFT || mode_chg) begin
         phase_q <= 5'h00;
         sclk_q  <= 1'b0;                                     // [R02]
         edge_q  <= 4'h0;
      end else if (toggle) begin
         phase_q <= 5'h00;
         sclk_q  <= ~sclk_q;                                  // [R12]
         if (fall) begin
            edge_q <= edge_q + 4'h1;
         end
      end else begin
         phase_q <= phase_q + 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // Receive shifter and results
   // ---------------------------------------------------------------
   // Synchroniser delay is far shorter than half a clock period
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_q <= '0;
      end else if (st_q == H_IDLE) begin
         rx_q <= '0;
      end else if (rise) begin
         rx_q <= {rx_q[RES_BITS-1:0], dout_s};                // [R13]
      end
   end

   // Marker lands in the top bit after thirteen samples
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data       <= '0;
         o_data_valid <= 1'b0;
         o_marker_err <= 1'b0;
      end else begin
         o_data_valid <= frame_done && !mode_chg;
         if (frame_done && !mode_chg) begin
            o_data       <= rx_q[RES_BITS-1:0];               // [R06]
            o_marker_err <= ~rx_q[RES_BITS];
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin drive and status flops
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pd_o_q  <= 1'b0;
         pd_oe_q <= 1'b0;
         o_ready <= 1'b0;
         o_busy  <= 1'b0;
      end else begin
         pd_o_q  <= (i_pd_mode == PD_INT_REF);                // [R16]
         pd_oe_q <= (i_pd_mode != PD_EXT_REF);                // [R16]
         o_ready <= (st_q == H_IDLE) && !i_start && !mode_chg;
         o_busy  <= (st_q == H_CONV) || (st_q == H_SHIFT) ||
                    (st_q == H_IDLE && i_start && !mode_chg);
      end
   end

   assign link.cs_n  = cs_n_q;
   assign link.sclk  = sclk_q;
   assign link.pd_o  = pd_o_q;
   assign link.pd_oe = pd_oe_q;

endmodule

// ===== hw/asr_link_if.sv
// Three-wire link plus three-level power-down pin between host and converter
`timescale 1ns/1ps
interface asr_link_if;

   // ---------------------------------------------------------------
   // Wires
   // ---------------------------------------------------------------
   logic cs_n;     // Select, active low
   logic sclk;     // Serial clock from host
   logic dout_o;   // Converter data drive value
   logic dout_oe;  // Converter data drive enable
   logic pd_o;     // Power-down pin drive value
   logic pd_oe;    // Power-down pin drive enable
   logic dout;     // Resolved data line

   // Undriven data line reads low, like a weak pull-down
   assign dout = dout_oe ? dout_o : 1'b0;

   modport host (
      output cs_n,
      output sclk,
      output pd_o,
      output pd_oe,
      input  dout
   );

   modport dev (
      input  cs_n,
      input  sclk,
      input  pd_o,
      input  pd_oe,
      output dout_o,
      output dout_oe
   );

endinterface

// ===== hw/asr_pkg.sv
// Shared constants and types of the serial converter readout link
package asr_pkg;

   // ---------------------------------------------------------------
   // Clock and result format
   // ---------------------------------------------------------------
   localparam int unsigned CLK_SYS_KHZ = 50000;
   localparam int unsigned RES_BITS    = 12;
   localparam int unsigned FRAME_EDGES = 13;  // Marker plus result bits

   // ---------------------------------------------------------------
   // Conversion and acquisition timing
   // ---------------------------------------------------------------
   localparam int unsigned T_CONV_NS   = 7500;
   // Longest time: round down
   localparam int unsigned CONV_CYC    = T_CONV_NS * CLK_SYS_KHZ / 1000000;
   localparam int unsigned STEP_CYC    = CONV_CYC / RES_BITS;
   localparam int unsigned T_ACQ_NS    = 1500;
   localparam int unsigned ACQ_CYC     =
      (T_ACQ_NS * CLK_SYS_KHZ + 999999) / 1000000;
   localparam int unsigned T_CS_HIGH_NS = 1500;
   localparam int unsigned CS_HIGH_CYC  =
      (T_CS_HIGH_NS * CLK_SYS_KHZ + 999999) / 1000000;
   localparam int unsigned GAP_CYC      =
      (CS_HIGH_CYC > ACQ_CYC) ? CS_HIGH_CYC : ACQ_CYC;

   // ---------------------------------------------------------------
   // Serial clock limits
   // ---------------------------------------------------------------
   localparam int unsigned SCLK_MAX_KHZ    = 2100;
   localparam int unsigned SCLK_PERIOD_CYC =
      (CLK_SYS_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
   localparam int unsigned T_PHASE_NS      = 200;
   localparam int unsigned PHASE_CYC       =
      (T_PHASE_NS * CLK_SYS_KHZ + 999999) / 1000000;
   localparam int unsigned HALF_CYC        =
      (PHASE_CYC > (SCLK_PERIOD_CYC + 1) / 2) ?
      PHASE_CYC : (SCLK_PERIOD_CYC + 1) / 2;

   // ---------------------------------------------------------------
   // Power-up and wake timing
   // ---------------------------------------------------------------
   localparam int unsigned T_RESET_NS      = 10000;
   localparam int unsigned RESET_CYC       =
      (T_RESET_NS * CLK_SYS_KHZ + 999999) / 1000000;
   localparam int unsigned T_REF_CHARGE_MS = 20;
   localparam int unsigned REF_CHARGE_CYC  = T_REF_CHARGE_MS * CLK_SYS_KHZ;
   localparam int unsigned T_WAKE_NS       = 4000;
   localparam int unsigned WAKE_CYC        =
      (T_WAKE_NS * CLK_SYS_KHZ + 999999) / 1000000;

   // ---------------------------------------------------------------
   // Power-down control modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PD_INT_REF,
      PD_EXT_REF,
      PD_OFF
   } asr_pd_mode_e;

endpackage

// ===== hw/asr_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module asr_sync #(
   parameter int unsigned WIDTH              = 1,
   parameter logic [WIDTH-1:0] RST_VAL       = '0
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // Levels
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

// ===== sim/adc_serial_conversion_readout_tb_top.sv
// Self-checking bench joining host and converter ends
`timescale 1ns/1ps
module adc_serial_conversion_readout_tb_top;
   import asr_pkg::*;
   logic         i_clk_sys = 0, i_rst_n = 0, i_start = 0, i_abort = 0;
   asr_pd_mode_e i_pd_mode = PD_INT_REF;
   logic [11:0]  i_sample = 12'h000, o_data, dev_res;
   logic         o_data_valid, o_marker_err, o_ready, o_busy;
   logic         rv, cv, ri, pd;
   logic [12:0]  rx_q = 13'h0000;
   logic [31:0]  seed = 32'h000136ea;
   int           num_errors = 0, cmp_count = 0, vld_cnt = 0;
   always #10 i_clk_sys = ~i_clk_sys;
   asr_link_if link ();
   // Short reference charge keeps the run brief
   asr_host #(.REF_CHARGE(200)) asr_host_inst (.i_clk_sys, .i_rst_n,
      .link(link), .i_pd_mode, .i_start, .i_abort, .o_data,
      .o_data_valid, .o_marker_err, .o_ready, .o_busy);
   asr_device asr_device_inst (.i_clk_sys, .i_rst_n, .link(link),
      .i_sample, .o_result(dev_res), .o_result_valid(rv),
      .o_converting(cv), .o_ref_internal(ri), .o_powered_down(pd));
   asr_link_sva asr_link_sva_inst (.i_clk_sys, .i_rst_n,
      .cs_n(link.cs_n), .sclk(link.sclk), .dout_o(link.dout_o),
      .dout_oe(link.dout_oe), .dout(link.dout));
   // Independent wire sampler on rising serial clock
   always @(posedge link.sclk) if (!link.cs_n) rx_q <= {rx_q[11:0], link.dout};
   always @(posedge i_clk_sys) if (o_data_valid === 1'b1) vld_cnt++;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Marker high, then result MSB first
   function automatic logic [12:0] exp_word(input logic [11:0] s);
      return {1'b1, s};
   endfunction
   task automatic chk(input logic [12:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic summarize;
      $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      while (o_ready !== 1'b1 && n < 4000) begin
         tick(1);
         n++;
      end
      if (n == 4000) chk(0, 1, "ready timeout");
   endtask
   // One start; abort mid-conversion or read the whole frame
   task automatic frame(input logic [11:0] s, input bit ab);
      int v0, n;
      wait_ready;
      v0 = vld_cnt;
      n = 0;
      i_sample = s;
      i_start = 1;
      tick(1);
      i_start = 0;
      tick(10);
      i_sample = 12'(xs()); // Late change must not leak in
      if (ab) begin
         tick(30);
         chk({cv, rv, o_busy, link.sclk}, 4'b1010, "converting");
         i_abort = 1;
         tick(1);
         i_abort = 0;
         tick(150);
         chk(13'(vld_cnt - v0), 0, "abort gave data");
         chk(link.dout_oe, 0, "float after abort");
         chk({cv, o_busy}, 2'b00, "idle after abort");
      end else begin
         while (vld_cnt == v0 && n < 1500) begin
            tick(1);
            n++;
         end
         chk({o_marker_err, o_data}, {1'b0, s}, "data");
         chk(rx_q, exp_word(s), "wire");
         chk(dev_res, s, "frozen sample");
         chk({o_busy, o_ready, rv}, 3'b001, "gap");
      end
   endtask
   initial begin
      tick(5);
      i_rst_n = 1;
      frame(12'h000, 0);
      frame(12'hfff, 0);
      frame(12'h800, 0);
      frame(12'h001, 0);
      $display("test corners done");
      repeat (12) frame(12'(xs()), 0);
      $display("test random done");
      frame(12'h5a5, 1);
      frame(12'ha5a, 0);
      $display("test abort done");
      wait_ready;
      i_pd_mode = PD_OFF;
      tick(600);
      chk({pd, o_ready, link.pd_oe, link.pd_o}, 4'b1010, "off");
      i_pd_mode = PD_EXT_REF;
      frame(12'h3c3, 0);
      chk({ri, link.pd_oe}, 2'b00, "ext ref");
      i_pd_mode = PD_INT_REF;
      frame(12'h7e1, 0);
      chk({ri, link.pd_oe, link.pd_o}, 3'b111, "int ref");
      $display("test modes done");
      summarize;
   end
   // Watchdog, well beyond the expected run
   initial begin
      tick(40000);
      num_errors++;
      summarize;
   end
endmodule

// ===== sim/asr_link_sva.sv
// Wire-level checks of the converter link
`timescale 1ns/1ps
module asr_link_sva (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Link wires
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic dout
);
   logic       conv_q, eoc_q, cs_q, sclk_q;
   logic [4:0] fall_q;
   logic [7:0] hi_q;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Frame phase tracking, select high clears the conversion, end and edge trackers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_q <= 1'b0;
         eoc_q  <= 1'b0;
         cs_q   <= 1'b1;  // Select idles high, no false start
         sclk_q <= 1'b0;
         fall_q <= 5'h00;
         hi_q <= 8'h00;
      end else begin
         cs_q   <= cs_n;
         sclk_q <= sclk;
         hi_q   <= cs_n ? hi_q + 8'(hi_q != 8'hff) : 8'h00;
         conv_q <= !cs_n && (cs_q || (conv_q && !dout));
         eoc_q  <= !cs_n && (eoc_q || (conv_q && dout));
         fall_q <= cs_n ? 5'h00 : fall_q + 5'(eoc_q && sclk_q && !sclk);
      end
   end
   // Ten samples cover the minimum phase
   sequence s_high;
      sclk [*8] ##1 sclk ##1 sclk;
   endsequence
   sequence s_start_low;
      ##[1:5] (dout_oe && !dout_o);
   endsequence
   a_float_idle_sel: assert property (cs_n [*5] |-> !dout_oe)
      else $error("data driven while deselected");
   a_start_drv_low: assert property ($fell(cs_n) |-> s_start_low)
      else $error("no low drive after start");
   a_sclk_quiet_conv: assert property (conv_q |-> !sclk)
      else $error("clock moved in conversion");
   a_eoc_in_time: assert property (
      $fell(cs_n) |-> ##[1:390] (dout || cs_n))
      else $error("end of conversion late");
   a_change_on_fall: assert property
      (!cs_n && eoc_q && $changed(dout) |-> $fell(sclk))
      else $error("data changed off falling edge");
   a_frame_edge_cnt: assert property (
      $rose(cs_n) && eoc_q |-> 32'(fall_q) + 32'(sclk_q && !sclk) == 13)
      else $error("frame edge count wrong");
   a_select_gap: assert property (
      $fell(cs_n) |-> hi_q >= 8'd75)
      else $error("select high too short");
   a_clk_high_phase: assert property ($rose(sclk) |-> s_high)
      else $error("clock high phase short");
endmodule
